/* File: hdl/adc_capture_consts.vh */
// constants for the serial converter capture and scan controller
`ifndef ADC_CAPTURE_CONSTS_VH
`define ADC_CAPTURE_CONSTS_VH
`define WORD_BITS 16
`define SYNC_CHAIN_LEN 16
`define CHAN_BITS 3
`define CHAN_COUNT 8
`define TAG_BITS 18
`define SETTLE_NS 3000
`define CLK_NS 50
`define CONV_PERIOD_CYC 400
`define BIT_TRANSFER_CLOCK_HALF_CYC 4
`define FIFO_DEPTH 4
`define FIFO_AW 2
`define SYNC_WARM_CYC 3'h4
`define ST_IDLE 2'h0
`define ST_SETTLE 2'h1
`define ST_CONV 2'h2
`define ST_WAIT 2'h3
`endif

/* File: hdl/word_fifo.v */
// small synchronous fifo with valid and ready on both sides
`include "adc_capture_consts.vh"
module word_fifo #(
  parameter WIDTH = 19,
  parameter DEPTH = `FIFO_DEPTH,
  parameter AW = `FIFO_AW
) (
  input wire clk,
  input wire rst_n,
  // fill side
  input wire in_valid,
  output wire in_ready,
  input wire [WIDTH-1:0] in_data,
  // drain side
  output wire out_valid,
  input wire out_ready,
  output reg [WIDTH-1:0] out_data
);
  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW-1:0] wr_ptr_ff;
  reg [AW-1:0] rd_ptr_ff;
  reg [AW:0] count_ff;
  wire push;
  wire pop;
  wire [AW:0] depth_w;
  assign depth_w = DEPTH[AW:0];
  assign in_ready = (count_ff != depth_w);
  assign out_valid = (count_ff != {(AW+1){1'b0}});
  assign push = in_valid & in_ready;
  assign pop = out_valid & out_ready;
  always @*
  begin
    out_data = mem[rd_ptr_ff];
  end
  always @(posedge clk)
  begin
    if (push)
      mem[wr_ptr_ff] <= in_data;
  end
  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      wr_ptr_ff <= {AW{1'b0}};
      rd_ptr_ff <= {AW{1'b0}};
      count_ff <= {(AW+1){1'b0}};
    end
    else
    begin
      if (push)
        wr_ptr_ff <= wr_ptr_ff + {{(AW-1){1'b0}}, 1'b1};
      if (pop)
        rd_ptr_ff <= rd_ptr_ff + {{(AW-1){1'b0}}, 1'b1};
      case ({push, pop})
        2'b10: count_ff <= count_ff + {{AW{1'b0}}, 1'b1};
        2'b01: count_ff <= count_ff - {{AW{1'b0}}, 1'b1};
        default: count_ff <= count_ff;
      endcase
    end
  end
endmodule

/* File: hdl/adc_scan_capture.v */
// host-side capture and multiplexer scan controller for a serial converter
//
// Contract
// - deserialize serial result into 16-bit word
// - word valid one cycle plus 17 clocks
// - shift data and delay sync in chain
// - load strobe latches word, then valid flag
// - read strobe clears the data-valid flag unless the fifo holds another word
// - data, clock, sync, convert, tag and polarity select cross barrier
// - counter scans eight mux channels as tags
// - convert waits 3us after channel change
// - address held one conversion before tagging
// - delay register kept for any scan order
// - tag register loads on sync, shifts out
`include "adc_capture_consts.vh"
module adc_scan_capture #(
  parameter CONV_PERIOD = `CONV_PERIOD_CYC,
  parameter BIT_TRANSFER_CLOCK_HALF = `BIT_TRANSFER_CLOCK_HALF_CYC,
  parameter SETTLE_CYC = (`SETTLE_NS + `CLK_NS - 1) / `CLK_NS
) (
  // clock and reset
  input wire CLK,
  input wire RSTN,
  // converter link
  output reg BIT_TRANSFER_CLOCK,
  output reg CONVERT_N,
  output reg TAG_IN,
  input wire SERIAL_RESULT_OUT,
  input wire SYNC_IN,
  output wire SYNC_POLARITY_SELECT,
  // multiplexer
  output reg [`CHAN_BITS-1:0] MUX_ADDR,
  // control
  input wire SCAN_EN,
  input wire SYNC_ACTIVE_HIGH,
  // parallel result port
  output wire DATA_VALID_FLAG,
  output wire [`WORD_BITS-1:0] DATA_WORD,
  output wire [`CHAN_BITS-1:0] DATA_CHAN,
  input wire READ_STROBE,
  output wire OVERRUN
);
  // sync polarity driven out to converter; host undoes it on the way in
  assign SYNC_POLARITY_SELECT = SYNC_ACTIVE_HIGH;

  // serial data and sync come in; the bit clock, convert, tag and polarity select
  // go out, so an isolated link needs six channels across the barrier
  // three-stage input synchronisers; change seen once stages 2 and 3 agree
  reg [2:0] sd_sync_ff;
  reg [2:0] sy_sync_ff;
  reg sd_ff;
  reg sy_ff;
  always @(posedge CLK or negedge RSTN)
  begin
    if (!RSTN)
    begin
      sd_sync_ff <= 3'h0;
      sy_sync_ff <= 3'h0;
      sd_ff <= 1'b0;
      sy_ff <= 1'b0;
    end
    else
    begin
      sd_sync_ff <= {sd_sync_ff[1:0], SERIAL_RESULT_OUT};
      sy_sync_ff <= {sy_sync_ff[1:0], SYNC_IN};
      if (sd_sync_ff[1] == sd_sync_ff[2])
        sd_ff <= sd_sync_ff[2];
      if (sy_sync_ff[1] == sy_sync_ff[2])
        sy_ff <= sy_sync_ff[2];
    end
  end
  // the sync stages reset low, which reads as an active pulse while the
  // select is low; sync stays off until the stages hold the pin
  reg [2:0] warm_ff;
  always @(posedge CLK or negedge RSTN)
  begin
    if (!RSTN)
      warm_ff <= 3'h0;
    else if (warm_ff != `SYNC_WARM_CYC)
      warm_ff <= warm_ff + 3'h1;
  end
  // sync normalised to active high whatever the select
  wire sync_act;
  assign sync_act = (warm_ff == `SYNC_WARM_CYC) &
                    (SYNC_ACTIVE_HIGH ? sy_ff : ~sy_ff);

  // bit clock made here by dividing CLK; a rise tick stands for its edge
  reg [7:0] div_ff;
  reg bit_transfer_clock_rise;
  always @(posedge CLK or negedge RSTN)
  begin
    if (!RSTN)
    begin
      div_ff <= 8'h00;
      BIT_TRANSFER_CLOCK <= 1'b0;
      bit_transfer_clock_rise <= 1'b0;
    end
    else
    begin
      bit_transfer_clock_rise <= 1'b0;
      if (div_ff == BIT_TRANSFER_CLOCK_HALF - 1)
      begin
        div_ff <= 8'h00;
        BIT_TRANSFER_CLOCK <= ~BIT_TRANSFER_CLOCK;
        bit_transfer_clock_rise <= ~BIT_TRANSFER_CLOCK;
      end
      else
        div_ff <= div_ff + 8'h01;
    end
  end
  // sample link inputs a half period after the rise, where the
  // synchronised data is settled; costs latency but avoids the edge
  reg samp_tick;
  always @(posedge CLK or negedge RSTN)
  begin
    if (!RSTN)
    begin
      samp_tick <= 1'b0;
    end
    else
    begin
      samp_tick <= (div_ff == BIT_TRANSFER_CLOCK_HALF - 1) & BIT_TRANSFER_CLOCK;
    end
  end

  // capture path: data shifter and sync delay chain
  // the sync sample and the sixteen data samples after it fill the chain
  // together, so the word is whole in the shifter when the chain end is
  // seen; no separate bit counter is needed
  reg [`WORD_BITS-1:0] shift_ff;
  reg [`SYNC_CHAIN_LEN-1:0] sync_chain_ff;
  reg [`WORD_BITS-1:0] word_ff;
  reg word_load_strobe;
  reg data_valid_ff;
  reg overrun_ff;
  wire chain_end;
  assign chain_end = sync_chain_ff[`SYNC_CHAIN_LEN-1];
  always @(posedge CLK or negedge RSTN)
  begin
    if (!RSTN)
    begin
      shift_ff <= {`WORD_BITS{1'b0}};
      sync_chain_ff <= {`SYNC_CHAIN_LEN{1'b0}};
      word_load_strobe <= 1'b0;
    end
    else if (samp_tick)
    begin
      shift_ff <= {shift_ff[`WORD_BITS-2:0], sd_ff};
      sync_chain_ff <= {sync_chain_ff[`SYNC_CHAIN_LEN-2:0], sync_act};
      word_load_strobe <= chain_end;
    end
    else
      word_load_strobe <= 1'b0;
  end

  // word and its channel leave through the fifo so a slow reader is
  // buffered; a full fifo drops the word and flags overrun
  reg [`CHAN_BITS-1:0] tag_hold_ff;
  wire fifo_in_ready;
  wire fifo_out_valid;
  wire [`WORD_BITS+`CHAN_BITS-1:0] fifo_out;
  wire pop_req;
  word_fifo #(
    .WIDTH(`WORD_BITS + `CHAN_BITS),
    .DEPTH(`FIFO_DEPTH),
    .AW(`FIFO_AW)
  ) u_fifo (
    .clk(CLK),
    .rst_n(RSTN),
    .in_valid(word_load_strobe),
    .in_ready(fifo_in_ready),
    .in_data({shift_ff, tag_hold_ff}),
    .out_valid(fifo_out_valid),
    .out_ready(pop_req),
    .out_data(fifo_out)
  );
  assign pop_req = fifo_out_valid & (~data_valid_ff | READ_STROBE);
  reg [`CHAN_BITS-1:0] chan_ff;
  always @(posedge CLK or negedge RSTN)
  begin
    if (!RSTN)
    begin
      word_ff <= {`WORD_BITS{1'b0}};
      chan_ff <= {`CHAN_BITS{1'b0}};
      data_valid_ff <= 1'b0;
      overrun_ff <= 1'b0;
    end
    else
    begin
      if (pop_req)
      begin
        word_ff <= fifo_out[`WORD_BITS+`CHAN_BITS-1:`CHAN_BITS];
        chan_ff <= fifo_out[`CHAN_BITS-1:0];
        data_valid_ff <= 1'b1; // set wins over read
      end
      else if (READ_STROBE)
        data_valid_ff <= 1'b0;
      if (word_load_strobe & ~fifo_in_ready)
        overrun_ff <= 1'b1;
      else if (READ_STROBE)
        overrun_ff <= 1'b0;
    end
  end
  assign DATA_WORD = word_ff;
  assign DATA_CHAN = chan_ff;
  assign DATA_VALID_FLAG = data_valid_ff;
  assign OVERRUN = overrun_ff;

  // scan sequencer: settle, convert, step channel, wait out the period
  // the channel steps as the convert ends, so it has the rest of the period to
  // settle; the delay register keeps the old channel for the tag of the
  // word now in conversion, whatever order the channels come in
  reg [1:0] state_ff;
  reg [15:0] cnt_ff;
  reg [`CHAN_BITS-1:0] addr_dly_ff;
  always @(posedge CLK or negedge RSTN)
  begin
    if (!RSTN)
    begin
      state_ff <= `ST_IDLE;
      cnt_ff <= 16'h0000;
      MUX_ADDR <= {`CHAN_BITS{1'b0}};
      addr_dly_ff <= {`CHAN_BITS{1'b0}};
      CONVERT_N <= 1'b1;
    end
    else
    begin
      case (state_ff)
        `ST_IDLE:
        begin
          CONVERT_N <= 1'b1;
          cnt_ff <= 16'h0000;
          if (SCAN_EN)
            state_ff <= `ST_SETTLE;
        end
        `ST_SETTLE:
        begin
          cnt_ff <= cnt_ff + 16'h0001;
          if (cnt_ff == SETTLE_CYC - 1)
          begin
            CONVERT_N <= 1'b0;
            cnt_ff <= 16'h0000;
            state_ff <= `ST_CONV;
          end
        end
        `ST_CONV:
        begin
          cnt_ff <= cnt_ff + 16'h0001;
          if (cnt_ff == 2 * BIT_TRANSFER_CLOCK_HALF - 1)
          begin
            CONVERT_N <= 1'b1;
            addr_dly_ff <= MUX_ADDR;
            MUX_ADDR <= MUX_ADDR + {{(`CHAN_BITS-1){1'b0}}, 1'b1};
            state_ff <= `ST_WAIT;
          end
        end
        `ST_WAIT:
        begin
          cnt_ff <= cnt_ff + 16'h0001;
          if (cnt_ff == CONV_PERIOD - SETTLE_CYC - 1)
          begin
            cnt_ff <= 16'h0000;
            state_ff <= SCAN_EN ? `ST_SETTLE : `ST_IDLE;
          end
        end
        default: state_ff <= `ST_IDLE;
      endcase
    end
  end

  // tag shifter: load on sync at a bit-clock rise, then shift MSB first
  // zeros follow the three tag bits; they land in the converter's
  // shifter after the tag and are never captured here
  reg [`CHAN_BITS-1:0] tag_sh_ff;
  always @(posedge CLK or negedge RSTN)
  begin
    if (!RSTN)
    begin
      tag_sh_ff <= {`CHAN_BITS{1'b0}};
      tag_hold_ff <= {`CHAN_BITS{1'b0}};
      TAG_IN <= 1'b0;
    end
    else if (bit_transfer_clock_rise)
    begin
      if (sync_act)
      begin
        tag_sh_ff <= addr_dly_ff;
        tag_hold_ff <= addr_dly_ff;
      end
      else
        tag_sh_ff <= {tag_sh_ff[`CHAN_BITS-2:0], 1'b0};
      TAG_IN <= sync_act ? addr_dly_ff[`CHAN_BITS-1]
                         : tag_sh_ff[`CHAN_BITS-2];
    end
  end
endmodule

/* File: bench/conv_model.sv */
// behavioural serial converter driven by the capture controller
module conv_model (
  input wire logic bclk,
  input wire logic conv_n,
  input wire logic tag_in,
  input wire logic pol,
  input wire logic [2:0] mux,
  output logic serial_result_out,
  output logic sync,
  output logic [2:0] tag_got
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [17:0] sr = 18'h0;
  logic [15:0] held = 16'h0;
  logic act = 1'b0;
  logic [1:0] tag_cnt = 2'h3;
  // the sample depends on the channel so the bench can tie word to tag
  always @(posedge bclk)
  begin
    act <= !conv_n;
    if (!conv_n)
      held <= {mux, 5'h15, mux, 5'h0a};
    if (act)
      sr <= {held, 2'h0};
    else
      sr <= {sr[16:0], tag_in};
    // keep the first three tag bits after each frame for the bench
    if (act)
      tag_cnt <= 2'h0;
    else if (tag_cnt != 2'h3)
    begin
      tag_cnt <= tag_cnt + 2'h1;
      tag_got <= {tag_got[1:0], tag_in};
    end
  end
  assign serial_result_out = sr[17];
  assign sync = act ~^ pol;
endmodule

/* File: bench/adc_scan_capture_sva.sv */
// port assertions for the scan and capture controller
module adc_scan_capture_sva #(
  parameter int SETTLE_CYC = 60
) (
  input wire logic CLK,
  input wire logic RSTN,
  input wire logic BIT_TRANSFER_CLOCK,
  input wire logic CONVERT_N,
  input wire logic TAG_IN,
  input wire logic SYNC_POLARITY_SELECT,
  input wire logic [2:0] MUX_ADDR,
  input wire logic SYNC_ACTIVE_HIGH,
  input wire logic DATA_VALID_FLAG,
  input wire logic [15:0] DATA_WORD,
  input wire logic [2:0] DATA_CHAN,
  input wire logic READ_STROBE
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [2:0] mux_q_ff;
  logic [9:0] settle_ff;
  // saturating count of cycles since the multiplexer address moved
  always @(posedge CLK or negedge RSTN)
  begin
    if (!RSTN)
    begin
      mux_q_ff <= 3'h0;
      settle_ff <= 10'h0;
    end
    else
    begin
      mux_q_ff <= MUX_ADDR;
      if (MUX_ADDR != mux_q_ff)
        settle_ff <= 10'h0;
      else if (settle_ff != 10'h3ff)
        settle_ff <= settle_ff + 10'h1;
    end
  end
  default clocking @(posedge CLK); endclocking
  default disable iff (!RSTN);
  sequence conv_pulse;
    !CONVERT_N[*8] ##1 CONVERT_N;
  endsequence
  sequence bclk_cycle;
    BIT_TRANSFER_CLOCK[*4] ##1 !BIT_TRANSFER_CLOCK[*4] ##1 BIT_TRANSFER_CLOCK;
  endsequence
  AST_CONV_PULSE: assert property ($fell(CONVERT_N) |-> conv_pulse)
    else $error("convert pulse width wrong");
  AST_BCLK_RATE: assert property ($rose(BIT_TRANSFER_CLOCK) |-> bclk_cycle)
    else $error("bit clock period wrong");
  AST_SETTLE: assert property ($fell(CONVERT_N) |-> settle_ff >= SETTLE_CYC - 1)
    else $error("convert too soon after channel change");
  AST_MUX_STEP: assert property (MUX_ADDR != $past(MUX_ADDR) |->
    MUX_ADDR == $past(MUX_ADDR) + 3'h1)
    else $error("channel did not step by one");
  AST_MUX_AFTER_CONV: assert property ($rose(CONVERT_N) |->
    ##[0:2] (MUX_ADDR != mux_q_ff))
    else $error("channel not advanced after convert");
  AST_WORD_TIME: assert property ($fell(CONVERT_N) && !DATA_VALID_FLAG |->
    ##[110:180] $rose(DATA_VALID_FLAG))
    else $error("word not valid in time");
  AST_VALID_CLEAR: assert property ($fell(DATA_VALID_FLAG) |-> $past(READ_STROBE))
    else $error("valid dropped without read");
  AST_WORD_HOLD: assert property (DATA_VALID_FLAG && !READ_STROBE |=>
    DATA_VALID_FLAG && $stable(DATA_WORD) && $stable(DATA_CHAN))
    else $error("unread word changed");
  AST_POLARITY: assert property (SYNC_POLARITY_SELECT == SYNC_ACTIVE_HIGH)
    else $error("polarity select mismatch");
  AST_TAG_EDGE: assert property ($changed(TAG_IN) |-> BIT_TRANSFER_CLOCK)
    else $error("tag changed in low phase");
endmodule
bind adc_scan_capture adc_scan_capture_sva #(.SETTLE_CYC(SETTLE_CYC)) u_sva (
  .CLK(CLK), .RSTN(RSTN), .BIT_TRANSFER_CLOCK(BIT_TRANSFER_CLOCK),
  .CONVERT_N(CONVERT_N), .TAG_IN(TAG_IN),
  .SYNC_POLARITY_SELECT(SYNC_POLARITY_SELECT), .MUX_ADDR(MUX_ADDR),
  .SYNC_ACTIVE_HIGH(SYNC_ACTIVE_HIGH), .DATA_VALID_FLAG(DATA_VALID_FLAG),
  .DATA_WORD(DATA_WORD), .DATA_CHAN(DATA_CHAN), .READ_STROBE(READ_STROBE)
);

/* File: bench/test_adc_scan_capture.sv */
// self-checking bench for the scan and capture controller
module test_adc_scan_capture;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic scan_en = 1'b0;
  logic pol = 1'b1;
  logic rd = 1'b0;
  wire bclk, conv_n, tag, serial_result_out, sync, pol_sel, valid, ovr;
  wire [2:0] mux, chan, tag_got;
  wire [15:0] word;
  int num_errors = 0;
  int checks = 0;
  int cyc = 0;
  initial
  begin
    forever #25 clk = ~clk;
  end
  adc_scan_capture DUT (
    .CLK(clk), .RSTN(rstn), .BIT_TRANSFER_CLOCK(bclk), .CONVERT_N(conv_n),
    .TAG_IN(tag), .SERIAL_RESULT_OUT(serial_result_out), .SYNC_IN(sync),
    .SYNC_POLARITY_SELECT(pol_sel), .MUX_ADDR(mux), .SCAN_EN(scan_en),
    .SYNC_ACTIVE_HIGH(pol), .DATA_VALID_FLAG(valid), .DATA_WORD(word),
    .DATA_CHAN(chan), .READ_STROBE(rd), .OVERRUN(ovr)
  );
  conv_model u_conv (
    .bclk(bclk), .conv_n(conv_n), .tag_in(tag), .pol(pol_sel), .mux(mux),
    .serial_result_out(serial_result_out), .sync(sync), .tag_got(tag_got)
  );
  task automatic chk(input bit ok, input string msg);
    checks++;
    if (!ok)
    begin
      num_errors++;
      $display("unexpected at %0t: %s", $time, msg);
    end
  endtask
  task automatic end_sim;
    $display("errors %0d checks %0d", num_errors, checks);
    if (num_errors == 0 && checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      chk(1'b0, "run too long");
      end_sim();
    end
  end
  task automatic do_reset(input logic p);
    @(posedge clk);
    rstn <= 1'b0;
    scan_en <= 1'b0;
    pol <= p;
    repeat (20) @(posedge clk);
    chk(conv_n === 1'b1 && valid === 1'b0 && mux === 3'h0 && ovr === 1'b0,
      "reset values");
    rstn <= 1'b1;
    @(posedge clk);
    scan_en <= 1'b1;
  endtask
  // waits for a word under a bound of more than one conversion period
  task automatic get(output logic [15:0] w, output logic [2:0] c);
    int n;
    n = 0;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (valid !== 1'b1 && n < 1000);
    chk(valid === 1'b1, "no word arrived");
    chk(word === {chan, 5'h15, chan, 5'h0a}, "word or tag wrong");
    w = word;
    c = chan;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
  endtask
  task automatic t_scan(input logic p);
    logic [15:0] w;
    logic [2:0] c;
    logic [2:0] last;
    do_reset(p);
    get(w, c);
    chk(tag_got === c, "tag bits wrong");
    last = c;
    for (int i = 0; i < 9; i++)
    begin
      get(w, c);
      chk(c === last + 3'h1, "channel order");
      chk(tag_got === c, "tag bits wrong");
      last = c;
    end
  endtask
  // the fifo only holds four words, so a sixth conversion must be dropped
  task automatic t_overrun;
    logic [15:0] w;
    logic [2:0] c;
    repeat (2800) @(posedge clk);
    chk(ovr === 1'b1 && valid === 1'b1, "no overrun");
    get(w, c);
    @(posedge clk);
    chk(ovr === 1'b0, "overrun not cleared");
    repeat (4) get(w, c);
    @(posedge clk);
    chk(valid === 1'b0, "fifo depth wrong");
  endtask
  initial
  begin
    t_scan(1'b1);
    t_overrun();
    t_scan(1'b0);
    end_sim();
  end
endmodule
